//--- rtl/sdc_device.sv
// cellular module end: shutdown, deep sleep, wake and fast power-down control
`timescale 1ns/10ps
`default_nettype none

module sdc_device #(
    parameter int unsigned SHDN_QUAL_CYC = sdc_pkg::SHDN_CYC,
    parameter int unsigned WAKE_ON_CYC   = sdc_pkg::WAKE_ON_CYC,
    parameter int unsigned WAKE_OFF_CYC  = sdc_pkg::WAKE_OFF_CYC,
    parameter int unsigned DETACH_CYC    = sdc_pkg::DETACH_CYC,
    parameter int unsigned POR_CYC       = sdc_pkg::POR_CYC,
    parameter int unsigned CNT_W         = sdc_pkg::CNT_W
) (
    input  wire logic                    i_clock,
    input  wire logic                    i_reset,
    input  wire logic                    i_clock_enable,
    sdc_link_if.device                   link,
    input  wire logic                    i_periodic_timer_expired,
    input  wire logic                    i_scheduled_wake,
    input  wire logic                    i_orderly_off_cmd,
    input  wire logic                    i_fast_power_down_command,
    input  wire logic                    i_fast_pd_gpio_enable,
    output var  sdc_pkg::sdc_dev_state_e o_state,
    output var  logic                    o_in_reset,
    output var  logic                    o_powered_on
);
    import sdc_pkg::*;

    localparam logic [CNT_W-1:0] SHDN_V     = CNT_W'(SHDN_QUAL_CYC);
    localparam logic [CNT_W-1:0] WAKE_ON_V  = CNT_W'(WAKE_ON_CYC);
    localparam logic [CNT_W-1:0] WAKE_OFF_V = CNT_W'(WAKE_OFF_CYC);
    localparam logic [CNT_W-1:0] DETACH_V   = CNT_W'(DETACH_CYC);
    localparam logic [CNT_W-1:0] POR_V      = CNT_W'(POR_CYC);

    typedef struct packed {
        sdc_dev_state_e   state;
        logic [CNT_W-1:0] cnt;
        logic             pwr_on;
        logic             usd_drive;
        logic             in_reset;
        logic             gpio_s1;
        logic             gpio_s2;
        logic             gpio_s3;
    } sdc_dev_s;

    sdc_dev_s         r_reg;
    sdc_dev_s         r_next;
    logic             usd_level;
    logic [CNT_W-1:0] usd_count;
    logic             wake_level;
    logic [CNT_W-1:0] wake_count;
    logic             usd_hit;
    logic             wake_hit_on;
    logic             wake_hit_off;
    logic             gpio_fall;
    logic             fast_req;

    // refuse timings the state machine cannot serve
    if (CNT_W > 31 || WAKE_OFF_CYC >= WAKE_ON_CYC || WAKE_ON_CYC + 1 >= (2 ** CNT_W) ||
        DETACH_CYC >= (2 ** CNT_W) || POR_CYC < 1 || SHDN_QUAL_CYC <= POR_CYC + 4)
    begin : g_bad_timing
        $error("sdc_device: timing parameters out of range");
    end

    // shutdown line: active low, measures how long it stays low
    sdc_hold_timer #(
        .ACTIVE_LEVEL (1'b0),
        .LIMIT        (SHDN_QUAL_CYC),
        .CNT_W        (CNT_W)
    ) u_usd_hold (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_pin          (link.unconditional_shutdown_n),
        .o_level        (usd_level),
        .o_count        (usd_count)
    );

    // wake request: active high, counts one past the longest threshold
    sdc_hold_timer #(
        .ACTIVE_LEVEL (1'b1),
        .LIMIT        (WAKE_ON_CYC + 1),
        .CNT_W        (CNT_W)
    ) u_wake_hold (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_pin          (link.wake_req),
        .o_level        (wake_level),
        .o_count        (wake_count)
    );

    // qualified events; the saturating wake count equals each threshold once per hold
    always_comb begin
        usd_hit      = usd_level && (usd_count == SHDN_V);
        wake_hit_on  = wake_level && (wake_count == WAKE_ON_V);
        wake_hit_off = wake_level && (wake_count == WAKE_OFF_V);
        gpio_fall    = i_fast_pd_gpio_enable && r_reg.gpio_s3 && !r_reg.gpio_s2;
        fast_req     = gpio_fall || i_fast_power_down_command;
    end

    // power state machine
    always_comb begin
        r_next         = r_reg;
        r_next.gpio_s1 = link.fast_pd_gpio;
        r_next.gpio_s2 = r_reg.gpio_s1;
        r_next.gpio_s3 = r_reg.gpio_s2;
        case (r_reg.state)
            DEV_OFF: begin
                // shutdown line has no effect while powered off
                if (wake_hit_on) begin
                    r_next.state     = DEV_POR;
                    r_next.cnt       = '0;
                    r_next.usd_drive = 1'b1;
                end
            end
            DEV_POR: begin
                // own reset pulse on the shutdown line; the line is not read here
                if (r_reg.cnt == POR_V - CNT_W'(1)) begin
                    r_next.state     = DEV_ON;
                    r_next.cnt       = '0;
                    r_next.usd_drive = 1'b0;
                    r_next.pwr_on    = 1'b1;
                end else begin
                    r_next.cnt = r_reg.cnt + CNT_W'(1);
                end
            end
            DEV_ON: begin
                if (usd_hit && r_reg.pwr_on) begin
                    r_next.state    = DEV_RESET;
                    r_next.in_reset = 1'b1;
                end else if (fast_req) begin
                    r_next.state = DEV_FAST;
                end else if (wake_hit_off || i_orderly_off_cmd) begin
                    r_next.state = DEV_DETACH;
                    r_next.cnt   = '0;
                end else if (i_periodic_timer_expired) begin
                    r_next.state  = DEV_SLEEP;
                    r_next.pwr_on = 1'b0;
                end
            end
            DEV_DETACH: begin
                // network detach and file system close take more than a second
                if (usd_hit && r_reg.pwr_on) begin
                    r_next.state    = DEV_RESET;
                    r_next.in_reset = 1'b1;
                end else if (fast_req) begin
                    r_next.state = DEV_FAST;
                end else if (r_reg.cnt == DETACH_V) begin
                    r_next.state  = DEV_OFF;
                    r_next.pwr_on = 1'b0;
                end else begin
                    r_next.cnt = r_reg.cnt + CNT_W'(1);
                end
            end
            DEV_FAST: begin
                // minimum time to power off, no detach
                r_next.state  = DEV_OFF;
                r_next.pwr_on = 1'b0;
            end
            DEV_RESET: begin
                // all operation stopped until the line is released
                if (!usd_level) begin
                    r_next.state    = DEV_OFF;
                    r_next.in_reset = 1'b0;
                    r_next.pwr_on   = 1'b0;
                end
            end
            DEV_SLEEP: begin
                // shutdown line toggles are ignored in deep sleep
                if (i_scheduled_wake || wake_hit_on) begin
                    r_next.state     = DEV_POR;
                    r_next.cnt       = '0;
                    r_next.usd_drive = 1'b1;
                end
            end
            default: begin
                r_next.state     = DEV_OFF;
                r_next.cnt       = '0;
                r_next.pwr_on    = 1'b0;
                r_next.usd_drive = 1'b0;
                r_next.in_reset  = 1'b0;
            end
        endcase
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            r_reg       <= '0;
            r_reg.state <= DEV_OFF;
        end else if (i_clock_enable) begin
            r_reg <= r_next;
        end
    end

    // pins and user outputs straight from the state register; the shutdown drive level is a constant low
    assign link.unconditional_shutdown_n_dev_out = 1'b0;
    assign link.unconditional_shutdown_n_dev_oe  = r_reg.usd_drive;
    assign link.power_on_indicator               = r_reg.pwr_on;
    assign o_state                               = r_reg.state;
    assign o_in_reset                            = r_reg.in_reset;
    assign o_powered_on                          = r_reg.pwr_on;
endmodule // sdc_device

`default_nettype wire

//--- rtl/sdc_pkg.sv
// constants and state types shared by both ends of the shutdown and deep sleep control link
package sdc_pkg;

    // clock rate and printed times
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned SHDN_MIN_MS   = 200;
    localparam int unsigned WAKE_ON_MIN_S = 5;
    localparam int unsigned WAKE_OFF_MIN_S = 3;
    localparam int unsigned DETACH_MIN_S  = 1;

    // cycle counts derived from the times (least times, detach one cycle longer, already whole cycles)
    localparam int unsigned SHDN_CYC      = SHDN_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned WAKE_ON_CYC   = WAKE_ON_MIN_S * CLK_HZ;
    localparam int unsigned WAKE_OFF_CYC  = WAKE_OFF_MIN_S * CLK_HZ;
    localparam int unsigned DETACH_CYC    = DETACH_MIN_S * CLK_HZ + 1;

    // internal start-up reset pulse, host margin, fast power-down low time and counter width
    localparam int unsigned POR_CYC       = 16;
    localparam int unsigned HOST_MARGIN_CYC = 4;
    localparam int unsigned GPIO_LOW_CYC  = 4;
    localparam int unsigned CNT_W         = 27;

    // reset levels
    localparam logic        USD_IDLE_LEVEL = 1'b1;
    localparam logic        WAKE_IDLE_LEVEL = 1'b0;

    typedef enum logic [2:0] {
        DEV_OFF    = 3'h0,
        DEV_POR    = 3'h1,
        DEV_ON     = 3'h2,
        DEV_DETACH = 3'h3,
        DEV_FAST   = 3'h4,
        DEV_RESET  = 3'h5,
        DEV_SLEEP  = 3'h6
    } sdc_dev_state_e;

    typedef enum logic [1:0] {
        HST_IDLE      = 2'h0,
        HST_USD_LOW   = 2'h1,
        HST_WAKE_HIGH = 2'h2,
        HST_GPIO_LOW  = 2'h3
    } sdc_host_state_e;

endpackage

//--- rtl/sdc_link_if.sv
// pins between the cellular module end and the host processor end
`timescale 1ns/10ps
`default_nettype none

interface sdc_link_if;
    logic unconditional_shutdown_n_host_out;
    logic unconditional_shutdown_n_host_oe;
    logic unconditional_shutdown_n_dev_out;
    logic unconditional_shutdown_n_dev_oe;
    logic unconditional_shutdown_n;
    logic wake_req;
    logic fast_pd_gpio;
    logic usb_power_sense;
    logic power_on_indicator;

    // open-drain line with internal pull-up: low when any enabled driver pulls low
    assign unconditional_shutdown_n =
        !((unconditional_shutdown_n_host_oe && !unconditional_shutdown_n_host_out) ||
          (unconditional_shutdown_n_dev_oe && !unconditional_shutdown_n_dev_out));

    modport device (
        input  unconditional_shutdown_n, wake_req, fast_pd_gpio, usb_power_sense,
        output unconditional_shutdown_n_dev_out, unconditional_shutdown_n_dev_oe,
        output power_on_indicator
    );

    modport host (
        input  unconditional_shutdown_n, power_on_indicator,
        output unconditional_shutdown_n_host_out, unconditional_shutdown_n_host_oe,
        output wake_req, fast_pd_gpio, usb_power_sense
    );
endinterface

`default_nettype wire

//--- rtl/sdc_hold_timer.sv
// pin synchroniser with a saturating hold-duration counter
`timescale 1ns/10ps
`default_nettype none

module sdc_hold_timer #(
    parameter logic        ACTIVE_LEVEL = 1'b1,
    parameter int unsigned LIMIT        = 16,
    parameter int unsigned CNT_W        = 27
) (
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    input  wire logic             i_clock_enable,
    input  wire logic             i_pin,
    output var  logic             o_level,
    output var  logic [CNT_W-1:0] o_count
);
    localparam logic [CNT_W-1:0] LIMIT_V = CNT_W'(LIMIT);

    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             lvl;
        logic [CNT_W-1:0] cnt;
    } sdc_hold_s;

    sdc_hold_s r_reg;
    sdc_hold_s r_next;

    // refuse a limit the counter cannot hold
    if (CNT_W > 31 || LIMIT < 1 || LIMIT >= (2 ** CNT_W)) begin : g_bad_limit
        $error("sdc_hold_timer: LIMIT does not fit CNT_W");
    end

    // two-flop sync, then count while the pin stays active
    always_comb begin
        r_next     = r_reg;
        r_next.s1  = i_pin;
        r_next.s2  = r_reg.s1;
        r_next.lvl = (r_reg.s2 == ACTIVE_LEVEL);
        if (r_reg.s2 != ACTIVE_LEVEL) begin
            r_next.cnt = '0;
        end else if (r_reg.cnt != LIMIT_V) begin
            r_next.cnt = r_reg.cnt + CNT_W'(1);
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            r_reg    <= '0;
            r_reg.s1 <= !ACTIVE_LEVEL;
            r_reg.s2 <= !ACTIVE_LEVEL;
        end else if (i_clock_enable) begin
            r_reg <= r_next;
        end
    end

    assign o_level = r_reg.lvl;
    assign o_count = r_reg.cnt;
endmodule // sdc_hold_timer

`default_nettype wire

//--- rtl/sdc_host.sv
// host processor end: drives shutdown, wake, fast power-down and usb sense pins
`timescale 1ns/10ps
`default_nettype none

module sdc_host #(
    parameter int unsigned SHDN_HOLD_CYC     = sdc_pkg::SHDN_CYC + sdc_pkg::HOST_MARGIN_CYC,
    parameter int unsigned WAKE_ON_HOLD_CYC  = sdc_pkg::WAKE_ON_CYC + sdc_pkg::HOST_MARGIN_CYC,
    parameter int unsigned WAKE_OFF_HOLD_CYC = sdc_pkg::WAKE_OFF_CYC + sdc_pkg::HOST_MARGIN_CYC,
    parameter int unsigned GPIO_LOW_CYC      = sdc_pkg::GPIO_LOW_CYC,
    parameter int unsigned CNT_W             = sdc_pkg::CNT_W
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_reset,
    input  wire logic                     i_clock_enable,
    sdc_link_if.host                      link,
    input  wire logic                     i_cmd_shutdown,
    input  wire logic                     i_cmd_wake_on,
    input  wire logic                     i_cmd_power_off,
    input  wire logic                     i_cmd_fast_pd,
    input  wire logic                     i_usb_present,
    input  wire logic                     i_sleep_permit,
    output var  sdc_pkg::sdc_host_state_e o_state,
    output var  logic                     o_busy,
    output var  logic                     o_device_on
);
    import sdc_pkg::*;

    typedef struct packed {
        sdc_host_state_e  state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] hold;
        logic             usd_oe;
        logic             wake;
        logic             gpio;
        logic             usb;
        logic             pmon_s1;
        logic             pmon_s2;
        logic             busy;
    } sdc_host_s;

    sdc_host_s r_reg;
    sdc_host_s r_next;

    // refuse hold times that the counter cannot hold
    if (CNT_W > 31 || WAKE_ON_HOLD_CYC >= (2 ** CNT_W) || SHDN_HOLD_CYC >= (2 ** CNT_W) ||
        WAKE_OFF_HOLD_CYC >= (2 ** CNT_W) || GPIO_LOW_CYC < 1 || SHDN_HOLD_CYC < 1 ||
        WAKE_OFF_HOLD_CYC < 1)
    begin : g_bad_hold
        $error("sdc_host: hold parameters out of range");
    end

    // pin sequencer: one command at a time, taken only when idle
    always_comb begin
        r_next         = r_reg;
        r_next.pmon_s1 = link.power_on_indicator;
        r_next.pmon_s2 = r_reg.pmon_s1;
        r_next.usb     = i_usb_present && !i_sleep_permit;
        case (r_reg.state)
            HST_IDLE: begin
                r_next.cnt = '0;
                if (i_cmd_shutdown) begin
                    r_next.state  = HST_USD_LOW;
                    r_next.hold   = CNT_W'(SHDN_HOLD_CYC);
                    r_next.usd_oe = 1'b1;
                end else if (i_cmd_wake_on) begin
                    r_next.state = HST_WAKE_HIGH;
                    r_next.hold  = CNT_W'(WAKE_ON_HOLD_CYC);
                    r_next.wake  = 1'b1;
                end else if (i_cmd_power_off) begin
                    r_next.state = HST_WAKE_HIGH;
                    r_next.hold  = CNT_W'(WAKE_OFF_HOLD_CYC);
                    r_next.wake  = 1'b1;
                end else if (i_cmd_fast_pd) begin
                    r_next.state = HST_GPIO_LOW;
                    r_next.hold  = CNT_W'(GPIO_LOW_CYC);
                    r_next.gpio  = 1'b0;
                end
            end
            HST_USD_LOW, HST_WAKE_HIGH, HST_GPIO_LOW: begin
                // hold the pin for the full count, then release it
                if (r_reg.cnt == r_reg.hold - CNT_W'(1)) begin
                    r_next.state  = HST_IDLE;
                    r_next.cnt    = '0;
                    r_next.usd_oe = 1'b0;
                    r_next.wake   = 1'b0;
                    r_next.gpio   = 1'b1;
                end else begin
                    r_next.cnt = r_reg.cnt + CNT_W'(1);
                end
            end
            default: begin
                r_next.state  = HST_IDLE;
                r_next.usd_oe = 1'b0;
                r_next.wake   = 1'b0;
                r_next.gpio   = 1'b1;
            end
        endcase
        r_next.busy = (r_next.state != HST_IDLE); // busy kept as a flop, not a decode
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            r_reg       <= '0;
            r_reg.state <= HST_IDLE;
            r_reg.gpio  <= 1'b1;
        end else if (i_clock_enable) begin
            r_reg <= r_next;
        end
    end

    // open-drain shutdown: only ever pulls low or floats
    assign link.unconditional_shutdown_n_host_out = 1'b0;
    assign link.unconditional_shutdown_n_host_oe  = r_reg.usd_oe;
    assign link.wake_req                          = r_reg.wake;
    assign link.fast_pd_gpio                      = r_reg.gpio;
    assign link.usb_power_sense                   = r_reg.usb;
    assign o_state                                = r_reg.state;
    assign o_busy                                 = r_reg.busy;
    assign o_device_on                            = r_reg.pmon_s2;
endmodule // sdc_host

`default_nettype wire

//--- tb/sdc_link_monitor.sv
// assertions on the pins between the two ends of the shutdown link
`timescale 1ns/10ps
`default_nettype none

module sdc_link_monitor #(
    parameter int unsigned SHDN_HOLD_CYC     = 44,
    parameter int unsigned WAKE_ON_HOLD_CYC  = 64,
    parameter int unsigned WAKE_OFF_HOLD_CYC = 34,
    parameter int unsigned WAKE_ON_CYC       = 60
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic unconditional_shutdown_n_host_out,
    input wire logic unconditional_shutdown_n_host_oe,
    input wire logic unconditional_shutdown_n_dev_out,
    input wire logic unconditional_shutdown_n_dev_oe,
    input wire logic unconditional_shutdown_n,
    input wire logic wake_req,
    input wire logic fast_pd_gpio,
    input wire logic power_on_indicator
);
    wire         h_oe = unconditional_shutdown_n_host_oe;
    wire         d_oe = unconditional_shutdown_n_dev_oe;
    wire         ln   = unconditional_shutdown_n;
    wire         pwr  = power_on_indicator;
    int unsigned h_cnt;
    int unsigned w_cnt;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // run lengths of the host pull and of the wake level
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            h_cnt <= 0;
            w_cnt <= 0;
        end else begin
            h_cnt <= h_oe ? h_cnt + 1 : 0;
            w_cnt <= wake_req ? w_cnt + 1 : 0;
        end
    end
    // properties of the wire and of the power states
    property p_pullup; !h_oe && !d_oe |-> ln; endproperty
    property p_odrain; (h_oe -> !unconditional_shutdown_n_host_out) &&
        (d_oe -> !unconditional_shutdown_n_dev_out); endproperty
    property p_shdn_hold; $fell(h_oe) |-> h_cnt == SHDN_HOLD_CYC; endproperty
    property p_wake_hold; $fell(wake_req) |->
        w_cnt == WAKE_ON_HOLD_CYC || w_cnt == WAKE_OFF_HOLD_CYC; endproperty
    property p_por; $rose(d_oe) |-> w_cnt >= WAKE_ON_CYC ##1 d_oe [*7]; endproperty
    property p_on; $rose(pwr) |-> $fell(d_oe); endproperty
    property p_reset; $rose(ln) && $past(pwr) |-> ##[1:5] !pwr; endproperty
    property p_fast; $fell(fast_pd_gpio) && pwr |-> ##[1:5] !pwr; endproperty
    property p_orderly; $fell(wake_req) && pwr |-> pwr [*8] ##[1:30] !pwr; endproperty
    a_pullup: assert property (p_pullup) else $error("idle line not high");
    a_odrain: assert property (p_odrain) else $error("line driven high");
    a_shdn_hold: assert property (p_shdn_hold) else $error("short hold");
    a_wake_hold: assert property (p_wake_hold) else $error("bad wake hold");
    a_por: assert property (p_por) else $error("bad start-up pulse");
    a_on: assert property (p_on) else $error("monitor rose early");
    a_reset: assert property (p_reset) else $error("no off on release");
    a_fast: assert property (p_fast) else $error("no fast off");
    a_orderly: assert property (p_orderly) else $error("bad orderly off");
    c_on: cover property ($rose(pwr));
    c_fast: cover property ($fell(fast_pd_gpio) && pwr);
    c_shdn: cover property ($rose(h_oe) && pwr);
endmodule // sdc_link_monitor

`default_nettype wire

//--- tb/testbench.sv
// self-checking bench joining the device end and the host end
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import sdc_pkg::*;
    localparam int unsigned QUAL = 40;
    localparam int unsigned WON  = 60;
    localparam int unsigned WOFF = 30;
    localparam int unsigned DET  = 20;
    logic            clock    = 1'b0;
    logic            reset    = 1'b1;
    logic [3:0]      cmd      = 4'h0;
    logic            fast_cmd = 1'b0;
    logic            ord      = 1'b0;
    logic            timer    = 1'b0;
    logic            usb      = 1'b0;
    logic            perm     = 1'b0;
    logic            in_rst;
    logic            pwr;
    logic            h_busy;
    logic            h_on;
    sdc_dev_state_e  d_st;
    sdc_host_state_e h_st;
    int              n_errors = 0;
    int              total_checks = 0;
    int              cyc = 0;
    int              n;
    int              k;
    int unsigned     r;
    sdc_link_if link ();
    sdc_device #(.SHDN_QUAL_CYC(QUAL), .WAKE_ON_CYC(WON), .WAKE_OFF_CYC(WOFF),
        .DETACH_CYC(DET), .POR_CYC(16)) i_sdc_device (.i_clock(clock), .i_reset(reset),
        .i_clock_enable(1'b1), .link(link), .i_periodic_timer_expired(timer),
        .i_scheduled_wake(1'b0), .i_orderly_off_cmd(ord), .i_fast_power_down_command(fast_cmd),
        .i_fast_pd_gpio_enable(1'b1), .o_state(d_st), .o_in_reset(in_rst), .o_powered_on(pwr));
    sdc_host #(.SHDN_HOLD_CYC(QUAL + 4), .WAKE_ON_HOLD_CYC(WON + 4),
        .WAKE_OFF_HOLD_CYC(WOFF + 4)) i_sdc_host (.i_clock(clock), .i_reset(reset),
        .i_clock_enable(1'b1), .link(link), .i_cmd_shutdown(cmd[0]), .i_cmd_wake_on(cmd[1]),
        .i_cmd_power_off(cmd[2]), .i_cmd_fast_pd(cmd[3]), .i_usb_present(usb),
        .i_sleep_permit(perm), .o_state(h_st), .o_busy(h_busy), .o_device_on(h_on));
    sdc_link_monitor #(.SHDN_HOLD_CYC(QUAL + 4), .WAKE_ON_HOLD_CYC(WON + 4),
        .WAKE_OFF_HOLD_CYC(WOFF + 4), .WAKE_ON_CYC(WON)) i_sdc_link_monitor (
        .i_clock(clock), .i_reset(reset),
        .unconditional_shutdown_n_host_out(link.unconditional_shutdown_n_host_out),
        .unconditional_shutdown_n_host_oe(link.unconditional_shutdown_n_host_oe),
        .unconditional_shutdown_n_dev_out(link.unconditional_shutdown_n_dev_out),
        .unconditional_shutdown_n_dev_oe(link.unconditional_shutdown_n_dev_oe),
        .unconditional_shutdown_n(link.unconditional_shutdown_n), .wake_req(link.wake_req),
        .fast_pd_gpio(link.fast_pd_gpio), .power_on_indicator(link.power_on_indicator));
    // clock and cycle ceiling
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    function automatic logic exp_usb(input logic p, input logic s);
        return p & ~s;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic wait_st(input sdc_dev_state_e e, input int lim);
        int i;
        i = 0;
        while (d_st !== e && i < lim) begin
            step();
            i++;
        end
        check(d_st, e);
    endtask
    // host command pulse, taken once the host is idle
    task automatic host_go(input int b);
        int i;
        i = 0;
        while (h_busy !== 1'b0 && i < 200) begin
            step();
            i++;
        end
        @(posedge clock);
        cmd[b] <= 1'b1;
        @(posedge clock);
        cmd[b] <= 1'b0;
        #1;
        check(h_busy, 1'b1);
        check(h_st, b == 0 ? HST_USD_LOW : b == 3 ? HST_GPIO_LOW : HST_WAKE_HIGH);
    endtask
    task automatic power_on();
        host_go(1);
        wait_st(DEV_POR, 90);
        check(link.unconditional_shutdown_n, 1'b0);
        wait_st(DEV_ON, 30);
        check(pwr, 1'b1);
        repeat (2) step();
        check(h_on, 1'b1);
    endtask
    // one way of leaving the on state
    task automatic off_by(input int w);
        case (w)
            0: begin
                host_go(3);
                wait_st(DEV_FAST, 10);
            end
            1: begin
                @(posedge clock);
                fast_cmd <= 1'b1;
                @(posedge clock);
                fast_cmd <= 1'b0;
                #1;
                check(d_st, DEV_FAST);
            end
            2, 4: begin
                // 4 takes the orderly command, 2 the short wake hold
                if (w == 4) begin
                    @(posedge clock);
                    ord <= 1'b1;
                    @(posedge clock);
                    ord <= 1'b0;
                    #1;
                end else begin
                    host_go(2);
                end
                wait_st(DEV_DETACH, 50);
                for (n = 0; d_st === DEV_DETACH && n < 99; n++) step();
                check(n, DET + 1);
            end
            default: begin
                host_go(0);
                wait_st(DEV_RESET, 60);
                check({in_rst, pwr}, 2'h3);
                for (n = 0; d_st === DEV_RESET && n < 30; n++) step();
            end
        endcase
        wait_st(DEV_OFF, 2);
        check(pwr, 1'b0);
    endtask
    // main sequence
    initial begin
        r = $urandom(87465);
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        host_go(0);
        repeat (60) step();
        check(d_st, DEV_OFF);
        for (k = 0; k < 8; k++) begin
            r = $urandom;
            @(posedge clock);
            usb <= r[0];
            perm <= r[1];
            repeat (2) step();
            check(link.usb_power_sense, exp_usb(usb, perm));
            check(h_on, 1'b0);
            repeat (r[5:2]) step();
            power_on();
            off_by(k < 5 ? k : r[7:6]);
            $display("test %0d done at %0t", k, $time);
        end
        power_on();
        @(posedge clock);
        timer <= 1'b1;
        @(posedge clock);
        timer <= 1'b0;
        wait_st(DEV_SLEEP, 4);
        check(pwr, 1'b0);
        host_go(0);
        repeat (60) step();
        check(d_st, DEV_SLEEP);
        power_on();
        $display("test sleep done at %0t", $time);
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
endmodule // testbench

`default_nettype wire
